// ==== src/emp_page_mapper.v ====
// Expanded-memory page mapper: port registers, page map, translation
//
// Operation
// - With auto-increment set, every data-port access advances the index by one; otherwise it holds.
// - The upper frame base select places the upper block at C4000, C8000, CC000 or D0000, resetting to C4000.
// - Mapping enable 00 disables all, 01 allows programming only, 10 maps upper frames, 11 maps upper and lower.
// - With the lower-bound enable set, memory above the boundary is reserved for mapping; clear ignores it.
// - The index holds six writable bits for entries 0..39, upper ten bits read zero, resets to zero.
// - Forty entries sit behind one data port, each access targeting the indexed entry.
// - Reset clears entries 32..39; entries 0..31 keep unknown contents.
// - Entries 32..39 each enable their own upper frame with bit 15.
// - Entries 0..31 are enabled as a group by enable code 11; their own enable bit is stored and read back but ignored.
// - Upper frames are eight 16K windows from the base, served by entries 32..39 cyclically.
// - Lower frames map entries 0..7 to 80000..9FFFF and entries 8..31 to 20000..7FFFF ascending.
// - Each entry holds a 12-bit page number in bits 11..0, enable in bit 15, bits 14..12 read zero.
// - A mapped access goes to page number times 16K plus the low 14 address bits.
`timescale 1ns/1ps
`include "emp_consts.vh"

module emp_page_mapper (
    // Clock and reset
    input wire ref_clk_in,
    input wire reset_n_in,
    // Host I/O port cycles
    input wire [15:0] io_addr_in,
    input wire io_wr_in,
    input wire io_rd_in,
    input wire [15:0] io_wdata_in,
    output reg [15:0] io_rdata_out,
    output reg io_rvalid_out,
    // Host memory cycles
    input wire mem_req_in,
    input wire [23:0] mem_addr_in,
    // Translated memory cycle
    output reg mem_valid_out,
    output reg [25:0] phys_addr_out,
    output reg mapped_out,
    output reg reserved_out
);

    // ------------------------------------------------------------
    // Port decode
    // ------------------------------------------------------------
    function port_hit;
        input [15:0] addr;
        input [15:0] port;
        begin
            port_hit = (addr == port);
        end
    endfunction

    wire ctrl_sel = port_hit(io_addr_in, `EMP_PORT_CTRL);
    wire index_sel = port_hit(io_addr_in, `EMP_PORT_INDEX);
    wire data_sel = port_hit(io_addr_in, `EMP_PORT_DATA);

    wire ctrl_wr = io_wr_in && ctrl_sel;
    wire index_wr = io_wr_in && index_sel;
    wire data_access = (io_wr_in || io_rd_in) && data_sel;

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    reg auto_inc_reg;
    reg [1:0] upper_frame_base_select_reg;
    reg [1:0] mapping_enable_field_reg;
    reg lower_bound_enable_reg;
    reg [6:0] lower_bound_address_reg;

    always @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            auto_inc_reg <= 1'b0;
            upper_frame_base_select_reg <= `EMP_RST_BASE;
            mapping_enable_field_reg <= `EMP_RST_MEN;
            lower_bound_enable_reg <= 1'b0;
            lower_bound_address_reg <= `EMP_RST_LBA;
        end else if (ctrl_wr) begin
            auto_inc_reg <= io_wdata_in[`EMP_CTRL_INC_BIT];
            upper_frame_base_select_reg <=
                io_wdata_in[`EMP_CTRL_BASE_HI:`EMP_CTRL_BASE_LO];
            mapping_enable_field_reg <=
                io_wdata_in[`EMP_CTRL_MEN_HI:`EMP_CTRL_MEN_LO];
            lower_bound_enable_reg <= io_wdata_in[`EMP_CTRL_LBEN_BIT];
            // Software's job to write start minus 128K here
            lower_bound_address_reg <=
                io_wdata_in[`EMP_CTRL_LBA_HI:`EMP_CTRL_LBA_LO];
        end
    end

    // ------------------------------------------------------------
    // Index register
    // ------------------------------------------------------------
    reg [5:0] index_reg;
    reg [5:0] index_next;

    // A direct index write wins over an increment in the same cycle
    always @* begin
        index_next = index_reg;
        if (index_wr) begin
            index_next = io_wdata_in[`EMP_INDEX_HI:0];
        end else if (data_access && auto_inc_reg) begin
            index_next = index_reg + 6'h01;
        end
    end

    always @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            index_reg <= `EMP_RST_INDEX;
        end else begin
            index_reg <= index_next;
        end
    end

    wire index_valid = (index_reg <= `EMP_ENTRY_LAST);
    // Programming is locked out only while mapping is fully off
    wire prog_allowed = (mapping_enable_field_reg != `EMP_MEN_OFF);
    wire data_wr = io_wr_in && data_sel && prog_allowed && index_valid;

    // ------------------------------------------------------------
    // Page-map entries
    // ------------------------------------------------------------
    wire [12:0] entry_word [0:`EMP_ENTRY_COUNT-1];

    genvar i;
    generate
        for (i = 0; i < `EMP_ENTRY_COUNT; i = i + 1) begin : gen_entry
            reg [11:0] page_reg;
            reg en_reg;
            wire sel = data_wr && ({26'h0000000, index_reg} == i);
            if (i >= `EMP_UPPER_FIRST) begin : g_rst
                always @(posedge ref_clk_in or negedge reset_n_in) begin
                    if (!reset_n_in) begin
                        page_reg <= `EMP_RST_PAGE;
                        en_reg <= 1'b0;
                    end else if (sel) begin
                        page_reg <=
                            io_wdata_in[`EMP_PAGE_HI:`EMP_PAGE_LO];
                        en_reg <= io_wdata_in[`EMP_ENTRY_EN_BIT];
                    end
                end
            end else begin : g_norst
                // No reset: contents are unknown until written
                always @(posedge ref_clk_in) begin
                    if (sel) begin
                        page_reg <=
                            io_wdata_in[`EMP_PAGE_HI:`EMP_PAGE_LO];
                        en_reg <= io_wdata_in[`EMP_ENTRY_EN_BIT];
                    end
                end
            end
            assign entry_word[i] = {en_reg, page_reg};
        end
    endgenerate

    // ------------------------------------------------------------
    // Port read-back
    // ------------------------------------------------------------
    reg [15:0] rdata_next;
    reg [12:0] sel_word;

    always @* begin
        sel_word = index_valid ? entry_word[index_reg] : 13'h0000;
        rdata_next = 16'h0000;
        if (ctrl_sel) begin
            rdata_next[`EMP_CTRL_INC_BIT] = auto_inc_reg;
            rdata_next[`EMP_CTRL_BASE_HI:`EMP_CTRL_BASE_LO] =
                upper_frame_base_select_reg;
            rdata_next[`EMP_CTRL_MEN_HI:`EMP_CTRL_MEN_LO] =
                mapping_enable_field_reg;
            rdata_next[`EMP_CTRL_LBEN_BIT] = lower_bound_enable_reg;
            rdata_next[`EMP_CTRL_LBA_HI:`EMP_CTRL_LBA_LO] =
                lower_bound_address_reg;
        end else if (index_sel) begin
            rdata_next = {10'h000, index_reg};
        end else if (data_sel) begin
            // Bits 14..12 stay zero
            rdata_next = {sel_word[12], 3'h0, sel_word[11:0]};
        end
    end

    always @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            io_rdata_out <= 16'h0000;
            io_rvalid_out <= 1'b0;
        end else begin
            io_rvalid_out <= io_rd_in;
            if (io_rd_in) begin
                io_rdata_out <= rdata_next;
            end
        end
    end

    // ------------------------------------------------------------
    // Memory translation
    // ------------------------------------------------------------
    wire frame_hit;
    wire frame_upper;
    wire [5:0] frame_entry;

    emp_frame_decode u_decode (
        .addr_in(mem_addr_in),
        .base_select_in(upper_frame_base_select_reg),
        .enable_field_in(mapping_enable_field_reg),
        .hit_out(frame_hit),
        .upper_out(frame_upper),
        .entry_out(frame_entry)
    );

    wire [12:0] hit_word = entry_word[frame_entry];
    // Lower entries ignore their stored bit under code 11
    wire entry_enabled = frame_upper ? hit_word[12] : 1'b1;
    wire do_map = frame_hit && entry_enabled;
    wire above_bound =
        lower_bound_enable_reg &&
        (mem_addr_in[23:17] > lower_bound_address_reg);

    always @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            mem_valid_out <= 1'b0;
            phys_addr_out <= 26'h0000000;
            mapped_out <= 1'b0;
            reserved_out <= 1'b0;
        end else begin
            mem_valid_out <= mem_req_in;
            if (mem_req_in) begin
                mapped_out <= do_map;
                reserved_out <= above_bound;
                if (do_map) begin
                    phys_addr_out <=
                        {hit_word[11:0], mem_addr_in[13:0]};
                end else begin
                    phys_addr_out <= {2'h0, mem_addr_in};
                end
            end
        end
    end

endmodule

// ==== src/emp_consts.vh ====
// Constants of the expanded-memory page mapper
`ifndef EMP_CONSTS_VH
`define EMP_CONSTS_VH

// ----------------------------------------------------------------
// I/O port offsets
// ----------------------------------------------------------------
`define EMP_PORT_CTRL 16'h6872
`define EMP_PORT_INDEX 16'hE072
`define EMP_PORT_DATA 16'hE872

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define EMP_CTRL_INC_BIT 15
`define EMP_CTRL_BASE_HI 14
`define EMP_CTRL_BASE_LO 13
`define EMP_CTRL_MEN_HI 11
`define EMP_CTRL_MEN_LO 10
`define EMP_CTRL_LBEN_BIT 7
`define EMP_CTRL_LBA_HI 6
`define EMP_CTRL_LBA_LO 0

// ----------------------------------------------------------------
// Mapping enable codes
// ----------------------------------------------------------------
`define EMP_MEN_OFF 2'h0
`define EMP_MEN_PROG 2'h1
`define EMP_MEN_UPPER 2'h2
`define EMP_MEN_BOTH 2'h3

// ----------------------------------------------------------------
// Entry fields and counts
// ----------------------------------------------------------------
`define EMP_ENTRY_EN_BIT 15
`define EMP_PAGE_HI 11
`define EMP_PAGE_LO 0
`define EMP_ENTRY_COUNT 40
`define EMP_ENTRY_LAST 6'h27
`define EMP_UPPER_FIRST 32
`define EMP_INDEX_HI 5

// ----------------------------------------------------------------
// Frame geometry, in 16K frame numbers (address bits 19..14)
// ----------------------------------------------------------------
`define EMP_FRAME_SHIFT 14
`define EMP_UPPER_BASE_FRAME 6'h31
`define EMP_LOWER_LO_FRAME 6'h08
`define EMP_LOWER_HI_FRAME 6'h1F
`define EMP_LOWER_CONV_HI 3'h4

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define EMP_RST_BASE 2'h0
`define EMP_RST_MEN 2'h0
`define EMP_RST_LBA 7'h00
`define EMP_RST_INDEX 6'h00
`define EMP_RST_PAGE 12'h000

`endif

// ==== src/emp_frame_decode.v ====
// Frame decoder: finds the page-map entry serving a memory address
`timescale 1ns/1ps
`include "emp_consts.vh"

module emp_frame_decode (
    // Address and configuration
    input wire [23:0] addr_in,
    input wire [1:0] base_select_in,
    input wire [1:0] enable_field_in,
    // Decode result
    output reg hit_out,
    output reg upper_out,
    output reg [5:0] entry_out
);

    reg [5:0] frame;
    reg [5:0] base_frame;
    reg [5:0] rel;
    reg below_1m;

    always @* begin
        frame = addr_in[19:14];
        below_1m = (addr_in[23:20] == 4'h0);
        base_frame = `EMP_UPPER_BASE_FRAME + {4'h0, base_select_in};
        rel = frame - base_frame;
        hit_out = 1'b0;
        upper_out = 1'b0;
        entry_out = 6'h00;
        // Eight frames from the base, entries 32..39 in cyclic order
        if (below_1m && enable_field_in[1] && frame >= base_frame &&
            rel < 6'h08) begin
            hit_out = 1'b1;
            upper_out = 1'b1;
            entry_out = {3'h4, frame[2:0]};
        end else if (below_1m && enable_field_in == `EMP_MEN_BOTH) begin
            if (frame[5:3] == `EMP_LOWER_CONV_HI) begin
                hit_out = 1'b1;
                entry_out = {3'h0, frame[2:0]};
            end else if (frame >= `EMP_LOWER_LO_FRAME &&
                         frame <= `EMP_LOWER_HI_FRAME) begin
                hit_out = 1'b1;
                entry_out = {1'b0, frame[4:0]};
            end
        end
    end

endmodule

// ==== verif/emp_page_mapper_checker.sv ====
// Timing and translation assertions for the page mapper
`timescale 1ns/1ps
module emp_page_mapper_checker (
    // Clock and reset
    input wire ref_clk_in,
    input wire reset_n_in,
    // Register port
    input wire [15:0] io_addr_in,
    input wire io_wr_in,
    input wire io_rd_in,
    input wire [15:0] io_wdata_in,
    input wire [15:0] io_rdata_out,
    input wire io_rvalid_out,
    // Memory cycles
    input wire mem_req_in,
    input wire [23:0] mem_addr_in,
    input wire mem_valid_out,
    input wire [25:0] phys_addr_out,
    input wire mapped_out,
    input wire reserved_out
);
    reg [15:0] ctrl_seen_reg;
    // Shadow of the control word, so enable-dependent checks need no probe
    always @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in)
            ctrl_seen_reg <= 16'h0000;
        else if (io_wr_in && io_addr_in == 16'h6872)
            ctrl_seen_reg <= io_wdata_in;
    end
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!reset_n_in);
    rd_answer_a: assert property (io_rd_in |=> io_rvalid_out)
        else $error("read not answered");
    rd_pulse_a: assert property (!io_rd_in |=> !io_rvalid_out)
        else $error("read valid without read");
    mem_answer_a: assert property (mem_req_in |=> mem_valid_out)
        else $error("memory cycle not answered");
    mem_pulse_a: assert property (!mem_req_in |=> !mem_valid_out)
        else $error("memory valid without request");
    idx_zero_a: assert property (io_rd_in && io_addr_in == 16'hE072
        |=> io_rdata_out[15:6] == 10'h000) else $error("index high bits set");
    entry_zero_a: assert property (io_rd_in && io_addr_in == 16'hE872
        |=> io_rdata_out[14:12] == 3'h0) else $error("entry bits 14:12 set");
    offset_keep_a: assert property (mem_req_in
        |=> phys_addr_out[13:0] == $past(mem_addr_in[13:0]))
        else $error("frame offset altered");
    pass_thru_a: assert property (mem_req_in |=> mapped_out ||
        phys_addr_out == {2'h0, $past(mem_addr_in)})
        else $error("unmapped address altered");
    high_nomap_a: assert property (mem_req_in &&
        mem_addr_in[23:20] != 4'h0 |=> !mapped_out)
        else $error("mapped above 1M");
    off_nomap_a: assert property (mem_req_in &&
        ctrl_seen_reg[11:10] < 2'h2 |=> !mapped_out)
        else $error("mapped while frames disabled");
    resv_off_a: assert property (mem_req_in &&
        !ctrl_seen_reg[7] |=> !reserved_out)
        else $error("reserved while boundary disabled");
    cover property (mem_req_in ##1 mapped_out);
    cover property (mem_req_in ##1 reserved_out);
    cover property (io_rd_in && io_addr_in == 16'hE872);
endmodule

bind emp_page_mapper emp_page_mapper_checker chk_u (
    .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
    .io_addr_in(io_addr_in), .io_wr_in(io_wr_in), .io_rd_in(io_rd_in),
    .io_wdata_in(io_wdata_in), .io_rdata_out(io_rdata_out),
    .io_rvalid_out(io_rvalid_out), .mem_req_in(mem_req_in),
    .mem_addr_in(mem_addr_in), .mem_valid_out(mem_valid_out),
    .phys_addr_out(phys_addr_out), .mapped_out(mapped_out),
    .reserved_out(reserved_out));

// ==== verif/emp_host_model.sv ====
// Host processor model issuing port and memory cycles
`timescale 1ns/1ps
module emp_host_model (
    // Clock
    input wire ref_clk_in,
    // Port cycles
    output logic [15:0] io_addr_out,
    output logic io_wr_out,
    output logic io_rd_out,
    output logic [15:0] io_wdata_out,
    input wire [15:0] io_rdata_in,
    // Memory cycles
    output logic mem_req_out,
    output logic [23:0] mem_addr_out,
    input wire [25:0] phys_addr_in,
    input wire mapped_in,
    input wire reserved_in
);
    initial begin
        io_addr_out = 16'h0000;
        io_wr_out = 1'b0;
        io_rd_out = 1'b0;
        io_wdata_out = 16'h0000;
        mem_req_out = 1'b0;
        mem_addr_out = 24'h000000;
    end
    // Released address and data lines are inverted so stale values never look valid
    task automatic io_cyc(input logic wr, input logic [15:0] a, d,
            output logic [15:0] q);
        @(posedge ref_clk_in);
        io_addr_out <= a;
        io_wdata_out <= d;
        io_wr_out <= wr;
        io_rd_out <= !wr;
        @(posedge ref_clk_in);
        io_wr_out <= 1'b0;
        io_rd_out <= 1'b0;
        io_addr_out <= ~a;
        io_wdata_out <= ~d;
        @(negedge ref_clk_in);
        q = io_rdata_in;
    endtask
    task automatic mem_cyc(input logic [23:0] a, output logic [27:0] r);
        @(posedge ref_clk_in);
        mem_addr_out <= a;
        mem_req_out <= 1'b1;
        @(posedge ref_clk_in);
        mem_req_out <= 1'b0;
        mem_addr_out <= ~a;
        @(negedge ref_clk_in);
        r = {reserved_in, mapped_in, phys_addr_in};
    endtask
endmodule

// ==== verif/emp_page_mapper_tb.sv ====
// Self-checking bench of the page mapper
`timescale 1ns/1ps
module emp_page_mapper_tb;
    logic ref_clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    wire [15:0] io_addr, io_wdata, io_rdata;
    wire io_wr, io_rd, io_rvalid, mem_req, mem_valid, mapped, resv;
    wire [23:0] mem_addr;
    wire [25:0] phys;
    logic [15:0] q, w, ctrl;
    logic [15:0] ent [40];
    logic [27:0] r;
    logic [23:0] a;
    int seed = 32'h855C25D9;
    int compares = 0;
    int num_errors = 0;
    always #12.5 ref_clk_in = ~ref_clk_in;
    emp_page_mapper dut_u (.ref_clk_in(ref_clk_in),
        .reset_n_in(reset_n_in), .io_addr_in(io_addr), .io_wr_in(io_wr),
        .io_rd_in(io_rd), .io_wdata_in(io_wdata), .io_rdata_out(io_rdata),
        .io_rvalid_out(io_rvalid), .mem_req_in(mem_req),
        .mem_addr_in(mem_addr), .mem_valid_out(mem_valid),
        .phys_addr_out(phys), .mapped_out(mapped), .reserved_out(resv));
    emp_host_model host_u (.ref_clk_in(ref_clk_in), .io_addr_out(io_addr),
        .io_wr_out(io_wr), .io_rd_out(io_rd), .io_wdata_out(io_wdata),
        .io_rdata_in(io_rdata), .mem_req_out(mem_req),
        .mem_addr_out(mem_addr), .phys_addr_in(phys), .mapped_in(mapped),
        .reserved_in(resv));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic chk(input string n, input logic [31:0] s, e);
        compares++;
        if (s !== e) begin
            num_errors++;
            $display("unexpected %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [15:0] ad, d);
        logic [15:0] x;
        host_u.io_cyc(1'b1, ad, d, x);
    endtask
    task automatic rd(input logic [15:0] ad, output logic [15:0] d);
        host_u.io_cyc(1'b0, ad, 16'h0000, d);
        chk("rvalid", io_rvalid, 1);
    endtask
    function automatic logic [27:0] xlate(input logic [23:0] ad);
        logic [5:0] f, e;
        logic hit;
        f = ad[19:14];
        e = 6'h00;
        hit = 1'b0;
        if (ad[23:20] == 4'h0 && ctrl[11] &&
                f - 6'h31 - {4'h0, ctrl[14:13]} < 6'h08) begin
            e = {3'h4, f[2:0]};
            hit = ent[e][15];
        end else if (ad[23:20] == 4'h0 && ctrl[11:10] == 2'h3 &&
                f >= 6'h08 && f <= 6'h27) begin
            e = (f >= 6'h20) ? f - 6'h20 : f;
            hit = 1'b1;
        end
        return {ctrl[7] && ad[23:17] > ctrl[6:0], hit,
            hit ? {ent[e][11:0], ad[13:0]} : {2'h0, ad}};
    endfunction
    task automatic wrap_up;
        $display("checks %0d errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        repeat (12) @(posedge ref_clk_in);
        reset_n_in <= 1'b1;
        rd(16'h6872, q);
        chk("ctrl reset", q, 0);
        rd(16'hE072, q);
        chk("index reset", q, 0);
        wr(16'hE072, 16'hFFFF);
        rd(16'hE072, q);
        chk("index mask", q, 16'h003F);
        wr(16'h6872, 16'hFFFF);
        rd(16'h6872, q);
        chk("ctrl fields", q, 16'hECFF);
        wr(16'h6872, 16'h8000);
        wr(16'hE072, 16'h0020);
        for (int i = 32; i < 40; i++) begin
            rd(16'hE872, q);
            chk("entry reset", q, 0);
        end
        rd(16'hE072, q);
        chk("index inc", q, 40);
        rd(16'hE872, q);
        chk("index beyond", q, 0);
        wr(16'hE072, 16'h0020);
        wr(16'hE872, 16'h8123);
        wr(16'hE072, 16'h0020);
        rd(16'hE872, q);
        chk("refused write", q, 0);
        $display("test reset and refusal done");
        wr(16'h6872, 16'h8400);
        wr(16'hE072, 16'h0000);
        for (int i = 0; i < 40; i++) begin
            w = $random(seed);
            ent[i] = w & 16'h8FFF;
            wr(16'hE872, w);
        end
        wr(16'hE072, 16'h0000);
        for (int i = 0; i < 40; i++) begin
            rd(16'hE872, q);
            chk("entry", q, ent[i]);
        end
        wr(16'h6872, 16'h0400);
        wr(16'hE072, 16'h0005);
        repeat (2) begin
            rd(16'hE872, q);
            chk("no inc entry", q, ent[5]);
        end
        rd(16'hE072, q);
        chk("no inc index", q, 5);
        $display("test page map done");
        for (int k = 0; k < 16; k++) begin
            w = $random(seed);
            // Boundary enable and address loaded with random bits
            ctrl = {1'b0, k[1:0], 1'b0, k[3:2], 2'h0, w[7:0]};
            wr(16'h6872, ctrl);
            for (int j = 0; j < 40; j++) begin
                w = $random(seed);
                a = $random(seed);
                if (w[1:0] != 2'h0)
                    a[23:20] = 4'h0;
                if (j == 0)
                    a = 24'h0C4000 + {8'h00, k[1:0], 14'h0000};
                if (j == 1)
                    a = 24'h0E3FFF + {8'h00, k[1:0], 14'h0000};
                if (j == 2)
                    a = 24'h0C3FFF + {8'h00, k[1:0], 14'h0000};
                if (j == 3)
                    a = 24'h0E4000 + {8'h00, k[1:0], 14'h0000};
                host_u.mem_cyc(a, r);
                chk("mem valid", mem_valid, 1);
                chk("xlate", r, xlate(a));
            end
        end
        $display("test translation done");
        wrap_up();
    end
    initial begin
        repeat (50000) @(posedge ref_clk_in);
        num_errors++;
        wrap_up();
    end
endmodule
